/* File: logic/ldoc_cfg.svh */
// Constants for the loop detector output control block
//
// Summary of operation
// - Nine sensitivity levels, continuous call, channel off
// - Continuous call forces Call, oscillator off, flashes
// - Channel off forces No Call, oscillator off, flashes
// - Call delay 0 to 255 s, presence relay
// - Delay counts from entry, remaining time shown
// - Extension 0 to 25.5 s in tenths
// - Extension counts from zone clear, call held
// - Entry during extension: Detect, full restart
// - Max presence off holds call; 1-999 s
// - Max presence counts from call; vacancy drops
// - Max presence zero triggers automatic detector reset
// - Inductance display, peak change held two seconds
// - Inductance display hides timers, ends after 15 min
// - Vehicle count wraps after 99999, shown optionally
// - Count clear option zeroes count, only means
// - Clear reverts itself; reset keeps the count
// - Buzzer sounds on secondary pulses, ends 15 min
// - Mode 5.0: count, quarter second per vehicle
// - Two vehicles over loop means tailgating
// - Modes 5.1-5.3 pulse on tailgating only
// - Modes 5.4-5.6 active: vehicles after the first
// - Modes 5.4-5.6 inactive: every vehicle pulses
// - Control polarity option inverts control input sense
`ifndef LDOC_CFG_SVH
`define LDOC_CFG_SVH

// Clock and tick timing
`define LDOC_CLK_HZ 20000000
`define LDOC_TICK_MS 50
`define LDOC_TICK_CYC (`LDOC_CLK_HZ / 1000 * `LDOC_TICK_MS)
`define LDOC_TENTH_MS 100
`define LDOC_TICKS_PER_TENTH (`LDOC_TENTH_MS / `LDOC_TICK_MS)
`define LDOC_TENTHS_PER_SEC 10

// Secondary relay pulse lengths in milliseconds and in ticks
`define LDOC_PULSE_Q_MS 250
`define LDOC_PULSE_1_MS 1000
`define LDOC_PULSE_5_MS 5000
`define LDOC_PULSE_Q_T 7'((`LDOC_PULSE_Q_MS) / `LDOC_TICK_MS)
`define LDOC_PULSE_1_T 7'((`LDOC_PULSE_1_MS) / `LDOC_TICK_MS)
`define LDOC_PULSE_5_T 7'((`LDOC_PULSE_5_MS) / `LDOC_TICK_MS)

// Option timeouts and peak hold, counted in tenths
`define LDOC_OPT_TO_MIN 15
`define LDOC_OPT_TO_T 14'(`LDOC_OPT_TO_MIN * 60 * `LDOC_TENTHS_PER_SEC)
`define LDOC_PEAK_HOLD_S 2
`define LDOC_PEAK_HOLD_T 5'(`LDOC_PEAK_HOLD_S * `LDOC_TENTHS_PER_SEC)

// Limits and codes
`define LDOC_COUNT_MAX 17'd99999
`define LDOC_MAXP_MAX 10'd999
`define LDOC_SENS_OFF 4'h0
`define LDOC_SENS_TOP 4'h9
`define LDOC_SENS_CALL 4'ha
`define LDOC_SENS_RST 4'h5
`define LDOC_MODE_TOP 3'h6
`define LDOC_THRESH_L1 12'h100

// Register byte addresses
`define LDOC_REG_SENS 8'h00
`define LDOC_REG_DELAY 8'h04
`define LDOC_REG_EXT 8'h08
`define LDOC_REG_MAXP 8'h0c
`define LDOC_REG_OPT 8'h10
`define LDOC_REG_STAT 8'h14
`define LDOC_REG_COUNT 8'h18
`define LDOC_REG_DISP 8'h1c

// Option register fields
`define LDOC_OPT_IND 0
`define LDOC_OPT_CNT 1
`define LDOC_OPT_CLR 2
`define LDOC_OPT_BUZZ 3
`define LDOC_OPT_POL 4
`define LDOC_OPT_MODE 7:5

// Bus responses
`define LDOC_RESP_OK 2'h0
`define LDOC_RESP_ERR 2'h2

`endif

/* File: logic/ldoc_pkg.sv */
// Types for the loop detector output control block
package ldoc_pkg;

  typedef enum logic [2:0] {P_IDLE, P_DELAY, P_DETECT, P_EXTEND, P_HOLD} ldoc_pres_e;

  typedef enum logic [3:0] {
    D_DASH, D_CALL, D_DELAY, D_EXT, D_MAXP, D_IND, D_DL, D_COUNT, D_FCALL, D_FOFF
  } ldoc_disp_e;

  typedef struct packed {
    logic [31:0] cnt;
    logic half;
    logic fast;
    logic tenth;
  } ldoc_tick_s;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] sens;
    logic [7:0] delay;
    logic [7:0] ext;
    logic [9:0] maxp;
    logic opt_ind;
    logic opt_cnt;
    logic opt_buzz;
    logic opt_pol;
    logic [2:0] mode;
    ldoc_pres_e pst;
    logic [11:0] tmr;
    logic [13:0] mp;
    logic relay_a;
    logic [6:0] rb_cnt;
    logic relay_b;
    logic buzz;
    logic [16:0] count;
    logic [13:0] ind_to;
    logic [13:0] buzz_to;
    logic [15:0] peak;
    logic [4:0] peak_to;
    logic gate_s1;
    logic gate_s2;
    logic gate_act;
    logic first_done;
    logic det_reset;
    logic osc_en;
    logic [11:0] thresh;
    ldoc_disp_e dmode;
    logic [16:0] dval;
  } ldoc_st_s;

endpackage

/* File: logic/ldoc_tick_if.sv */
// Tick enables shared between the tick generator and the control logic
`timescale 1ns/1ns
interface ldoc_tick_if;
  logic fast;
  logic tenth;
  modport src (output fast, output tenth);
  modport dst (input fast, input tenth);
endinterface

/* File: logic/ldoc_tick.sv */
// Tick generator: one pulse per tick period and one per tenth of a second
`timescale 1ns/1ns
`include "ldoc_cfg.svh"
module ldoc_tick import ldoc_pkg::*; #(
  parameter int TICK_CYCLES = `LDOC_TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Tick enables
  ldoc_tick_if.src tk
);
  ldoc_tick_s st;
  ldoc_tick_s next_st;

  always_comb begin
    next_st = st;
    next_st.fast = 1'b0;
    next_st.tenth = 1'b0;
    if (st.cnt == 32'(TICK_CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.fast = 1'b1;
      next_st.half = ~st.half;
      next_st.tenth = st.half;
    end else begin
      next_st.cnt = st.cnt + 32'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.fast = st.fast;
  assign tk.tenth = st.tenth;
endmodule

/* File: logic/ldoc_top.sv */
// Loop detector output control: relays, timers, count and register slave
`timescale 1ns/1ns
`include "ldoc_cfg.svh"
module ldoc_top import ldoc_pkg::*; #(
  parameter int TICK_CYCLES = `LDOC_TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Loop front end
  input wire logic veh_present,
  input wire logic veh_cross,
  input wire logic veh_tailgate,
  input wire logic [11:0] loop_uh,
  input wire logic [15:0] dl_pct,
  output logic osc_enable,
  output logic [11:0] det_threshold,
  output logic det_reset,
  // Gate control pin
  input wire logic gate_ctrl,
  // Relays, buzzer and display
  output logic relay_a,
  output logic relay_b,
  output logic buzzer,
  output ldoc_disp_e disp_mode,
  output logic [16:0] disp_value
);
  ldoc_st_s st;
  ldoc_st_s next_st;
  ldoc_tick_if tk ();

  ldoc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  logic wr_go;
  logic clr_go;
  logic act;
  logic first_eff;
  logic ev;
  logic [6:0] len;
  logic in_call;
  logic [9:0] mp_new;

  always_comb begin
    next_st = st;
    wr_go = st.aw_got && st.w_got;
    clr_go = 1'b0;
    act = 1'b0;
    first_eff = 1'b0;
    ev = 1'b0;
    len = `LDOC_PULSE_Q_T;
    in_call = (st.pst == P_DETECT) || (st.pst == P_EXTEND);
    mp_new = st.maxp;
    next_st.det_reset = 1'b0;

    // Gate pin synchroniser and polarity
    next_st.gate_s1 = gate_ctrl;
    next_st.gate_s2 = st.gate_s1;
    act = st.gate_s2 ^ st.opt_pol;
    next_st.gate_act = act;

    // Option timeouts
    if (tk.tenth && st.ind_to != '0) begin
      next_st.ind_to = st.ind_to - 14'd1;
      if (st.ind_to == 14'd1) begin
        next_st.opt_ind = 1'b0;
      end
    end
    if (tk.tenth && st.buzz_to != '0) begin
      next_st.buzz_to = st.buzz_to - 14'd1;
      if (st.buzz_to == 14'd1) begin
        next_st.opt_buzz = 1'b0;
      end
    end

    // Write address and data may arrive in either order
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `LDOC_RESP_OK;
      case (st.awaddr)
        `LDOC_REG_SENS: begin
          if (st.wstrb[0] && st.wdata[3:0] <= `LDOC_SENS_CALL) begin
            next_st.sens = st.wdata[3:0];
          end
        end
        `LDOC_REG_DELAY: begin
          if (st.wstrb[0]) begin
            next_st.delay = st.wdata[7:0];
          end
        end
        `LDOC_REG_EXT: begin
          if (st.wstrb[0]) begin
            next_st.ext = st.wdata[7:0];
          end
        end
        `LDOC_REG_MAXP: begin
          if (st.wstrb[0]) begin
            mp_new[7:0] = st.wdata[7:0];
          end
          if (st.wstrb[1]) begin
            mp_new[9:8] = st.wdata[9:8];
          end
          if (mp_new <= `LDOC_MAXP_MAX) begin
            next_st.maxp = mp_new;
          end
        end
        `LDOC_REG_OPT: begin
          if (st.wstrb[0]) begin
            next_st.opt_ind = st.wdata[`LDOC_OPT_IND];
            next_st.ind_to = st.wdata[`LDOC_OPT_IND] ?
              (st.opt_ind ? next_st.ind_to : `LDOC_OPT_TO_T) : '0;
            next_st.opt_cnt = st.wdata[`LDOC_OPT_CNT];
            next_st.opt_buzz = st.wdata[`LDOC_OPT_BUZZ];
            next_st.buzz_to = st.wdata[`LDOC_OPT_BUZZ] ?
              (st.opt_buzz ? next_st.buzz_to : `LDOC_OPT_TO_T) : '0;
            next_st.opt_pol = st.wdata[`LDOC_OPT_POL];
            clr_go = st.wdata[`LDOC_OPT_CLR];
            if (st.wdata[`LDOC_OPT_MODE] <= `LDOC_MODE_TOP) begin
              next_st.mode = st.wdata[`LDOC_OPT_MODE];
            end
          end
        end
        `LDOC_REG_STAT, `LDOC_REG_COUNT, `LDOC_REG_DISP: begin
          next_st.bresp = `LDOC_RESP_OK;
        end
        default: begin
          next_st.bresp = `LDOC_RESP_ERR;
        end
      endcase
    end

    // Read channel
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `LDOC_RESP_OK;
      next_st.rdata = '0;
      case (araddr)
        `LDOC_REG_SENS: next_st.rdata[3:0] = st.sens;
        `LDOC_REG_DELAY: next_st.rdata[7:0] = st.delay;
        `LDOC_REG_EXT: next_st.rdata[7:0] = st.ext;
        `LDOC_REG_MAXP: next_st.rdata[9:0] = st.maxp;
        `LDOC_REG_OPT: begin
          next_st.rdata[`LDOC_OPT_IND] = st.opt_ind;
          next_st.rdata[`LDOC_OPT_CNT] = st.opt_cnt;
          next_st.rdata[`LDOC_OPT_BUZZ] = st.opt_buzz;
          next_st.rdata[`LDOC_OPT_POL] = st.opt_pol;
          next_st.rdata[`LDOC_OPT_MODE] = st.mode;
        end
        `LDOC_REG_STAT: begin
          next_st.rdata[0] = st.relay_a;
          next_st.rdata[1] = st.relay_b;
          next_st.rdata[2] = st.gate_act;
          next_st.rdata[3] = st.osc_en;
          next_st.rdata[6:4] = st.pst;
        end
        `LDOC_REG_COUNT: next_st.rdata[16:0] = st.count;
        `LDOC_REG_DISP: begin
          next_st.rdata[16:0] = st.dval;
          next_st.rdata[23:20] = st.dmode;
        end
        default: next_st.rresp = `LDOC_RESP_ERR;
      endcase
    end

    // Secondary relay events
    first_eff = (act != st.gate_act) ? 1'b0 : st.first_done;
    next_st.first_done = first_eff;
    unique case (st.mode)
      3'h0: ev = veh_cross;
      3'h1, 3'h2, 3'h3: ev = veh_tailgate;
      default: begin
        ev = veh_cross && (!act || first_eff);
        if (veh_cross && act) begin
          next_st.first_done = 1'b1;
        end
      end
    endcase
    unique case (st.mode)
      3'h2: len = `LDOC_PULSE_1_T;
      3'h3, 3'h6: len = `LDOC_PULSE_5_T;
      default: len = `LDOC_PULSE_Q_T;
    endcase
    if (clr_go) begin
      next_st.count = '0;
    end
    if (ev) begin
      next_st.count = (next_st.count == `LDOC_COUNT_MAX) ? '0 :
        next_st.count + 17'd1;
      next_st.rb_cnt = len;
    end else if (tk.fast && st.rb_cnt != '0) begin
      next_st.rb_cnt = st.rb_cnt - 7'd1;
    end
    next_st.relay_b = next_st.rb_cnt != '0;
    next_st.buzz = next_st.relay_b && next_st.opt_buzz;

    // Presence state machine
    if (st.sens == `LDOC_SENS_OFF || st.sens == `LDOC_SENS_CALL) begin
      next_st.pst = P_IDLE;
    end else begin
      unique case (st.pst)
        P_IDLE: begin
          if (veh_present) begin
            next_st.mp = 14'(st.maxp * `LDOC_TENTHS_PER_SEC);
            if (st.delay == '0) begin
              next_st.pst = P_DETECT;
            end else begin
              next_st.pst = P_DELAY;
              next_st.tmr = 12'(st.delay * `LDOC_TENTHS_PER_SEC);
            end
          end
        end
        P_DELAY: begin
          if (!veh_present) begin
            next_st.pst = P_IDLE;
          end else if (tk.tenth) begin
            next_st.tmr = st.tmr - 12'd1;
            if (st.tmr <= 12'd1) begin
              next_st.pst = P_DETECT;
              next_st.mp = 14'(st.maxp * `LDOC_TENTHS_PER_SEC);
            end
          end
        end
        P_DETECT: begin
          if (!veh_present) begin
            next_st.pst = (st.ext == '0) ? P_IDLE : P_EXTEND;
            next_st.tmr = {4'h0, st.ext};
          end
        end
        P_EXTEND: begin
          if (veh_present) begin
            next_st.pst = P_DETECT;
          end else if (tk.tenth) begin
            next_st.tmr = st.tmr - 12'd1;
            if (st.tmr <= 12'd1) begin
              next_st.pst = P_IDLE;
            end
          end
        end
        P_HOLD: begin
          if (!veh_present) begin
            next_st.pst = P_IDLE;
          end
        end
      endcase
      if (in_call && st.maxp != '0 && tk.tenth && next_st.pst != P_IDLE) begin
        next_st.mp = st.mp - 14'd1;
        if (st.mp <= 14'd1) begin
          next_st.pst = P_HOLD;
          next_st.det_reset = 1'b1;
        end
      end
    end
    unique case (st.sens)
      `LDOC_SENS_OFF: next_st.relay_a = 1'b0;
      `LDOC_SENS_CALL: next_st.relay_a = 1'b1;
      default: next_st.relay_a = (next_st.pst == P_DETECT) ||
        (next_st.pst == P_EXTEND);
    endcase
    next_st.osc_en = (st.sens != `LDOC_SENS_OFF) && (st.sens <= `LDOC_SENS_TOP);
    next_st.thresh = next_st.osc_en ? (`LDOC_THRESH_L1 >> (st.sens - 4'h1)) : '0;

    // Peak change hold while the inductance display is on
    if (in_call && st.opt_ind) begin
      if (dl_pct > st.peak) begin
        next_st.peak = dl_pct;
        next_st.peak_to = `LDOC_PEAK_HOLD_T;
      end else if (tk.tenth) begin
        if (st.peak_to != '0) begin
          next_st.peak_to = st.peak_to - 5'd1;
        end else begin
          next_st.peak = dl_pct;
        end
      end
    end else begin
      next_st.peak = '0;
      next_st.peak_to = '0;
    end

    // Display selection
    next_st.dval = '0;
    if (st.sens == `LDOC_SENS_CALL) begin
      next_st.dmode = D_FCALL;
    end else if (st.sens == `LDOC_SENS_OFF) begin
      next_st.dmode = D_FOFF;
    end else if (st.opt_cnt) begin
      next_st.dmode = D_COUNT;
      next_st.dval = st.count;
    end else if (st.opt_ind) begin
      next_st.dmode = in_call ? D_DL : D_IND;
      next_st.dval = in_call ? {1'b0, st.peak} : {5'h0, loop_uh};
    end else if (st.pst == P_DELAY) begin
      next_st.dmode = D_DELAY;
      next_st.dval = {5'h0, st.tmr};
    end else if (st.pst == P_EXTEND) begin
      next_st.dmode = D_EXT;
      next_st.dval = {5'h0, st.tmr};
    end else if (in_call && st.maxp != '0) begin
      next_st.dmode = D_MAXP;
      next_st.dval = {3'h0, st.mp};
    end else begin
      next_st.dmode = in_call ? D_CALL : D_DASH;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.pst <= P_IDLE;
      st.dmode <= D_DASH;
      st.sens <= `LDOC_SENS_RST;
      st.osc_en <= 1'b1;
      st.thresh <= `LDOC_THRESH_L1 >> (`LDOC_SENS_RST - 4'h1);
      st.count <= st.count;
    end else begin
      st <= next_st;
    end
  end

  // Handshake outputs
  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  // Registered outputs
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign relay_a = st.relay_a;
  assign relay_b = st.relay_b;
  assign buzzer = st.buzz;
  assign osc_enable = st.osc_en;
  assign det_threshold = st.thresh;
  assign det_reset = st.det_reset;
  assign disp_mode = st.dmode;
  assign disp_value = st.dval;
endmodule

/* File: verification/ldoc_top_properties.sv */
// Port checker for the loop detector output control block
`timescale 1ns/1ns
module ldoc_top_properties import ldoc_pkg::*; #(
  parameter int TICK_CYCLES = 1000000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Loop events
  input wire logic veh_present,
  input wire logic veh_cross,
  input wire logic veh_tailgate,
  // Observed outputs
  input wire logic osc_enable,
  input wire logic [11:0] det_threshold,
  input wire logic det_reset,
  input wire logic relay_a,
  input wire logic relay_b,
  input wire logic buzzer,
  input wire ldoc_disp_e disp_mode,
  input wire logic [16:0] disp_value
);
  // Cycles of relay B high since the last event
  int run;
  always_ff @(posedge aclk) begin
    if (!aresetn || !relay_b || veh_cross || veh_tailgate) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FCALL: assert property (disp_mode == D_FCALL |-> relay_a && !osc_enable)
    else $error("call state without call");
  AST_FOFF: assert property (disp_mode == D_FOFF |-> !relay_a && !osc_enable)
    else $error("off state with call");
  AST_THRESH: assert property (osc_enable |-> $onehot(det_threshold) && det_threshold <= 12'h100)
    else $error("threshold not a power of two");
  AST_RST_PULSE: assert property (det_reset |=> !det_reset)
    else $error("detector reset too long");
  AST_RST_DROP: assert property (det_reset |-> ##[0:1] !relay_a)
    else $error("call kept after reset");
  AST_BUZZ: assert property (buzzer |-> relay_b)
    else $error("buzzer without relay B");
  AST_RB_LEN: assert property (run <= 100 * TICK_CYCLES + 2)
    else $error("relay B pulse too long");
  AST_RB_CAUSE: assert property ($rose(relay_b) |-> $past(veh_cross || veh_tailgate))
    else $error("relay B without event");
  AST_RA_CAUSE: assert property ($rose(relay_a) |-> $past(veh_present) || !osc_enable)
    else $error("call without vehicle");
  AST_COUNT: assert property (disp_mode == D_COUNT |-> disp_value <= 17'd99999)
    else $error("count out of range");
endmodule

/* File: verification/ldoc_gate_model.sv */
// Gate equipment model: drives the control input and counts relay B pulses
`timescale 1ns/1ns
module ldoc_gate_model (
  // Clock
  input wire logic aclk,
  // Request and observed relay
  input wire logic gate_req,
  input wire logic relay_b,
  // Control input and pulse tally
  output logic gate_ctrl,
  output int b_pulses
);
  logic rb_q = 1'b0;
  initial gate_ctrl = 1'b0;
  initial b_pulses = 0;
  always @(posedge aclk) begin
    gate_ctrl <= gate_req;
    rb_q <= relay_b;
    if (relay_b && !rb_q) begin
      b_pulses <= b_pulses + 1;
    end
  end
endmodule

/* File: verification/tb_loop_detector_output_control.sv */
// Testbench for the loop detector output control block
`timescale 1ns/1ns
module tb_loop_detector_output_control;
  import ldoc_pkg::*;
  localparam int T = 4;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic veh_present = 0;
  logic veh_cross = 0;
  logic veh_tailgate = 0;
  logic gate_req = 0;
  logic [11:0] loop_uh = 12'h0c8;
  logic [15:0] dl_pct = 16'h0010;
  logic osc_enable, det_reset, relay_a, relay_b, buzzer, gate_ctrl, seen;
  logic [11:0] det_threshold;
  ldoc_disp_e disp_mode;
  logic [16:0] disp_value;
  int bad_count = 0;
  int n_tests = 0;
  int b_pulses, c, ep;
  int tbl[11][5] = '{'{0,0,0,0,5}, '{1,0,0,1,5}, '{2,0,0,1,20}, '{3,0,0,1,100},
    '{1,0,0,0,0}, '{4,0,0,0,5}, '{6,0,0,0,100}, '{5,0,1,0,0}, '{5,0,1,0,5},
    '{5,1,1,0,5}, '{5,1,0,0,0}};
  always #25 aclk = ~aclk;
  ldoc_top #(.TICK_CYCLES(T)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .veh_present, .veh_cross, .veh_tailgate, .loop_uh, .dl_pct,
    .osc_enable, .det_threshold, .det_reset, .gate_ctrl, .relay_a, .relay_b, .buzzer,
    .disp_mode, .disp_value);
  ldoc_gate_model i_gate (.aclk, .gate_req, .relay_b, .gate_ctrl, .b_pulses);
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    $display("mismatch at %0t: timeout", $time);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [31:0] v, input int lo, input int hi);
    chk({31'b0, v >= lo && v <= hi}, 1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      k++;
      if (k > 50) hang();
    end while (!tb);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, tb;
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tb = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
      k++;
      if (k > 50) hang();
    end while (!tb);
  endtask
  task automatic wait_on(input logic rst, input logic want, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 3000) hang();
    end while ((rst ? det_reset : relay_a) !== want);
  endtask
  task automatic ev(input logic tail, input int ticks);
    int n;
    @(posedge aclk);
    veh_cross <= !tail;
    veh_tailgate <= tail;
    @(posedge aclk);
    veh_cross <= 1'b0;
    veh_tailgate <= 1'b0;
    @(negedge aclk);
    chk(buzzer, ticks != 0);
    n = 0;
    while (relay_b === 1'b1) begin
      @(negedge aclk);
      n++;
      if (n > 1000) hang();
    end
    if (ticks == 0) rng(n, 0, 0);
    else rng(n, (ticks - 1) * T, ticks * T + 1);
  endtask
  initial begin
    ep = 0;
    cyc(8);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(det_threshold, 12'h010);
    rdr(8'h00);
    chk(rd, 5);
    rdr(8'h20);
    chk(rs, 2'h2);
    wr(8'h20, 32'h1);
    chk(rs, 2'h2);
    for (int l = 1; l < 10; l++) begin
      wr(8'h00, l);
      cyc(2);
      chk(det_threshold, 12'h100 >> (l - 1));
      chk(osc_enable, 1);
      chk(rs, 2'h0);
    end
    wr(8'h00, 10);
    cyc(3);
    chk({relay_a, osc_enable}, 2'b10);
    chk(disp_mode, D_FCALL);
    rdr(8'h14);
    chk(rd, 32'h1);
    rdr(8'h1c);
    chk(rd[23:20], D_FCALL);
    wr(8'h00, 0);
    veh_present <= 1'b1;
    cyc(3);
    chk({relay_a, osc_enable}, 2'b00);
    chk(disp_mode, D_FOFF);
    veh_present <= 1'b0;
    wr(8'h00, 5);
    wr(8'h10, 32'h4);
    rdr(8'h10);
    chk(rd[2], 0);
    rdr(8'h18);
    chk(rd, 0);
    for (int i = 0; i < 11; i++) begin
      wr(8'h10, 32'(tbl[i][0] * 32 + tbl[i][1] * 16 + 8));
      gate_req <= tbl[i][2][0];
      cyc(6);
      ev(tbl[i][3][0], tbl[i][4]);
      if (tbl[i][4] != 0) ep++;
      rdr(8'h18);
      chk(rd, ep);
    end
    chk(b_pulses, ep);
    wr(8'h10, 32'h2);
    cyc(2);
    chk(disp_mode, D_COUNT);
    chk(disp_value, ep);
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    rdr(8'h18);
    chk(rd, ep);
    wr(8'h04, 1);
    wr(8'h08, 5);
    veh_present <= 1'b1;
    cyc(3);
    chk(disp_mode, D_DELAY);
    rng(disp_value, 9, 10);
    wait_on(0, 1, c);
    rng(c + 3, 18 * T, 20 * T + 3);
    @(posedge aclk);
    veh_present <= 1'b0;
    cyc(3);
    chk(relay_a, 1);
    chk(disp_mode, D_EXT);
    rng(disp_value, 4, 5);
    veh_present <= 1'b1;
    cyc(3);
    chk(relay_a, 1);
    veh_present <= 1'b0;
    wait_on(0, 0, c);
    rng(c, 8 * T, 10 * T + 3);
    wr(8'h04, 0);
    wr(8'h08, 0);
    wr(8'h0c, 1);
    veh_present <= 1'b1;
    wait_on(1, 1, c);
    rng(c, 18 * T, 20 * T + 3);
    cyc(3);
    chk(relay_a, 0);
    veh_present <= 1'b0;
    wr(8'h0c, 2);
    veh_present <= 1'b1;
    cyc(40);
    chk(relay_a, 1);
    chk(disp_mode, D_MAXP);
    rng(disp_value, 14, 16);
    veh_present <= 1'b0;
    wait_on(0, 0, c);
    rng(c, 1, 2);
    seen = 0;
    repeat (200) begin
      @(negedge aclk);
      seen |= det_reset;
    end
    chk(seen, 0);
    @(posedge aclk);
    wr(8'h10, 32'h9);
    cyc(3);
    chk(disp_mode, D_IND);
    chk(disp_value, 17'h000c8);
    veh_present <= 1'b1;
    cyc(4);
    chk(disp_mode, D_DL);
    chk(disp_value, 17'h00010);
    dl_pct <= 16'h0005;
    cyc(40);
    chk(disp_value, 17'h00010);
    veh_present <= 1'b0;
    cyc(9000 * 2 * T - 200);
    rdr(8'h10);
    chk(rd[3:0], 4'h9);
    cyc(220);
    rdr(8'h10);
    chk(rd[3:0], 0);
    end_of_test();
  end
endmodule
bind ldoc_top ldoc_top_properties #(.TICK_CYCLES(TICK_CYCLES)) i_props (.aclk, .aresetn,
  .veh_present, .veh_cross, .veh_tailgate, .osc_enable, .det_threshold, .det_reset, .relay_a,
  .relay_b, .buzzer, .disp_mode, .disp_value);
